// file: sosc_pkg.sv
// Constants, codes and states of the safety output state controller
// Overview of operation
// RL1: Automatic start: after power-up, run as soon as the zone is clear.
// RL2: An object entering the zone trips both safety outputs off.
// RL3: Any fault enters fault hold, outputs off, left only through full self-test.
// RL4: That self-test starts at power cycling or on a start input transition.
// RL5: Run: both outputs on, green on, red and yellow off.
// RL6: Stop: both outputs off, green off, red on.
// RL7: Start-wait option: wait after power-up; start transition before first run.
// RL8: Start-wait option: after first start behave exactly as automatic start.
// RL9: Restart-wait option: wait at power-up and after each zone stop.
// RL10: Status codes -1 to -5 go to the programming module only.
// RL11: Fault codes go to beam indicators and module; status codes never to beams.
// RL12: Power-up lights every display segment, then shows the version code.
// RL13: Configuration faults raise codes 21, 22, 23, 24 and 26.
// RL14: Output faults raise 31 shorted together, 32/33 to power, 34/35 to ground.
// RL15: Feedback not open before run 41, after run 42, wrong at power-up 43.
// RL16: Monitor fault at power-up 44, control logic fault 50, crosstalk 60.
// RL17: Only in fault: yellow flashes, ten beam indicators show the fault code.
// RL18: First fault code latched for reading, cleared by a passing self-test.
package sosc_pkg;
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_TIME_US   = 1000;
  localparam int TICK_CYC_DEF   = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int LAMP_TIME_MS   = 1000;
  localparam int VER_TIME_MS    = 1000;
  localparam int FB_TIME_MS     = 100;
  localparam int SETTLE_TIME_MS = 1;
  localparam int FLASH_TIME_MS  = 250;
  localparam int TEST_TIME_NS   = 400;
  localparam int TEST_CYC       = (TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 11;
  localparam int BEAM_W         = 10;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_FAULT   = 8'h08;
  localparam logic [7:0] ADDR_VERSION = 8'h0C;

  // Control register fields
  localparam int CTRL_W         = 6;
  localparam int CTRL_OPT_LSB   = 0;
  localparam int CTRL_FB_EN     = 2;
  localparam int CTRL_FLOAT     = 3;
  localparam int CTRL_FIXED     = 4;
  localparam int CTRL_MUTE      = 5;
  localparam logic [5:0] CTRL_RST = 6'h04;
  localparam int STAT_CODE_LSB  = 8;

  localparam logic [1:0] OPT_AUTO    = 2'h0;
  localparam logic [1:0] OPT_START   = 2'h1;
  localparam logic [1:0] OPT_RESTART = 2'h2;

  // Fault flag input bits
  localparam int FLG_MODE     = 0;
  localparam int FLG_SWCHG    = 1;
  localparam int FLG_MISMATCH = 2;
  localparam int FLG_STORE    = 3;
  localparam int FLG_SCAN     = 4;
  localparam int FLG_LOGIC    = 5;
  localparam int FLG_XTALK    = 6;
  localparam int FLG_MONITOR  = 7;

  localparam logic [7:0] CODE_NONE     = 8'h00;
  localparam logic [7:0] CODE_MODE     = 8'h15;
  localparam logic [7:0] CODE_SWCHG    = 8'h16;
  localparam logic [7:0] CODE_MISMATCH = 8'h17;
  localparam logic [7:0] CODE_STORE    = 8'h18;
  localparam logic [7:0] CODE_SCAN     = 8'h1A;
  localparam logic [7:0] CODE_SHORT12  = 8'h1F;
  localparam logic [7:0] CODE_PWR1     = 8'h20;
  localparam logic [7:0] CODE_PWR2     = 8'h21;
  localparam logic [7:0] CODE_GND1     = 8'h22;
  localparam logic [7:0] CODE_GND2     = 8'h23;
  localparam logic [7:0] CODE_FB_PRE   = 8'h29;
  localparam logic [7:0] CODE_FB_POST  = 8'h2A;
  localparam logic [7:0] CODE_FB_PWRUP = 8'h2B;
  localparam logic [7:0] CODE_MONITOR  = 8'h2C;
  localparam logic [7:0] CODE_LOGIC    = 8'h32;
  localparam logic [7:0] CODE_XTALK    = 8'h3C;

  // Signed status codes for the programming module
  localparam logic [7:0] STAT_WAIT  = 8'hFF;
  localparam logic [7:0] STAT_FLOAT = 8'hFE;
  localparam logic [7:0] STAT_FIXED = 8'hFD;
  localparam logic [7:0] STAT_BOTH  = 8'hFC;
  localparam logic [7:0] STAT_MUTE  = 8'hFB;
  localparam logic [7:0] STAT_LAMP  = 8'h88;
  // Arbitrary version value
  localparam logic [7:0] VERSION_CODE = 8'h01;

  typedef enum logic [2:0] {
    ST_LAMP, ST_VER, ST_TEST, ST_WAIT, ST_RUN, ST_STOP, ST_FAULT
  } sosc_state_t;
endpackage

// file: sosc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sosc_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK_IN,
  input  wire logic         RST_N_IN,
  input  wire logic [W-1:0] D_IN,
  output logic      [W-1:0] Q_OUT
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= D_IN;
      q_ff    <= meta_ff;
    end
  end

  assign Q_OUT = q_ff;
endmodule

// file: sosc_ctrl.sv
// Safety output state controller with APB register slave
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sosc_ctrl #(
  parameter int TICK_CYC = sosc_pkg::TICK_CYC_DEF
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        ZONE_BLOCKED_IN,
  input  wire logic [7:0]  FAULT_FLAGS_IN,
  input  wire logic        START_IN,
  input  wire logic        FEEDBACK_IN,
  input  wire logic        SENSE1_IN,
  input  wire logic        SENSE2_IN,
  output logic             SAFETY_OUT1_OUT,
  output logic             SAFETY_OUT2_OUT,
  output logic             LED_RUN_OUT,
  output logic             LED_STOP_OUT,
  output logic             LED_WAIT_OUT,
  output logic [9:0]       BEAM_IND_OUT,
  output logic [7:0]       PM_CODE_OUT
);
  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 32768) $error("TICK_CYC out of range");
  end

  localparam logic [14:0] TICK_LAST  = 15'(TICK_CYC - 1);
  localparam logic [10:0] LAMP_LAST  = 11'(sosc_pkg::LAMP_TIME_MS - 1);
  localparam logic [10:0] VER_LAST   = 11'(sosc_pkg::VER_TIME_MS - 1);
  localparam logic [10:0] FB_TICKS   = 11'(sosc_pkg::FB_TIME_MS);
  localparam logic [10:0] SETTLE     = 11'(sosc_pkg::SETTLE_TIME_MS);
  localparam logic [10:0] FLASH_LAST = 11'(sosc_pkg::FLASH_TIME_MS - 1);
  localparam logic [10:0] TEST_LAST  = 11'(sosc_pkg::TEST_CYC - 1);
  localparam logic [10:0] CNT_MAX    = 11'h7FF;

  // Config and internal fault flags map to one code, lowest bit first
  function automatic logic [7:0] flag_code(input logic [7:0] f);
    logic [7:0] c;
    c = sosc_pkg::CODE_NONE;
    if (f[sosc_pkg::FLG_XTALK])    c = sosc_pkg::CODE_XTALK;
    if (f[sosc_pkg::FLG_LOGIC])    c = sosc_pkg::CODE_LOGIC;
    if (f[sosc_pkg::FLG_SCAN])     c = sosc_pkg::CODE_SCAN;
    if (f[sosc_pkg::FLG_STORE])    c = sosc_pkg::CODE_STORE;
    if (f[sosc_pkg::FLG_MISMATCH]) c = sosc_pkg::CODE_MISMATCH;
    if (f[sosc_pkg::FLG_SWCHG])    c = sosc_pkg::CODE_SWCHG;
    if (f[sosc_pkg::FLG_MODE])     c = sosc_pkg::CODE_MODE;
    return c;
  endfunction

  logic [3:0]            pins_s;
  logic                  start_s;
  logic                  fb_s;
  logic                  sns1_s;
  logic                  sns2_s;
  sosc_pkg::sosc_state_t state_ff;
  sosc_pkg::sosc_state_t nxt_state;
  logic [10:0]           cnt_ff;
  logic [10:0]           nxt_cnt;
  logic [14:0]           tick_cnt_ff;
  logic [14:0]           nxt_tick_cnt;
  logic [10:0]           flash_cnt_ff;
  logic [10:0]           nxt_flash_cnt;
  logic                  flash_ff;
  logic                  nxt_flash;
  logic                  start_prev_ff;
  logic                  first_ff;
  logic                  nxt_first;
  logic [7:0]            fault_ff;
  logic [7:0]            nxt_fault;
  logic [7:0]            pm_ff;
  logic [7:0]            nxt_pm;
  logic [9:0]            beam_ff;
  logic [9:0]            nxt_beam;
  logic [5:0]            ctrl_ff;
  logic [5:0]            nxt_ctrl;
  logic [31:0]           prdata_ff;
  logic [31:0]           nxt_prdata;
  logic                  tick;
  logic                  start_rise;
  logic                  test_pass;
  logic [7:0]            det;
  logic [1:0]            opt;
  logic                  fb_en;
  logic                  fb_bad;
  logic                  mapped;

  sosc_sync #(.W(4)) u_sync (
    .CLK_IN   (CLK_IN),
    .RST_N_IN (RST_N_IN),
    .D_IN     ({START_IN, FEEDBACK_IN, SENSE1_IN, SENSE2_IN}),
    .Q_OUT    (pins_s)
  );

  assign start_s    = pins_s[3];
  assign fb_s       = pins_s[2];
  assign sns1_s     = pins_s[1];
  assign sns2_s     = pins_s[0];
  assign tick       = (tick_cnt_ff == TICK_LAST);
  assign start_rise = start_s && !start_prev_ff;
  assign opt        = ctrl_ff[sosc_pkg::CTRL_OPT_LSB +: 2];
  assign fb_en      = ctrl_ff[sosc_pkg::CTRL_FB_EN];
  // Feedback high means contactors released
  assign fb_bad     = fb_en && !fb_s;

  // State machine; power and ground readback checks wait a full tick out the sync lag
  always_comb begin
    nxt_state = state_ff;
    nxt_first = first_ff;
    det       = sosc_pkg::CODE_NONE;
    test_pass = 1'b0;
    nxt_cnt   = (tick && cnt_ff != CNT_MAX) ? cnt_ff + 11'h001 : cnt_ff;
    case (state_ff)
      sosc_pkg::ST_LAMP: begin
        if (tick && cnt_ff == LAMP_LAST) nxt_state = sosc_pkg::ST_VER;              // [RL12]
      end
      sosc_pkg::ST_VER: begin
        if (tick && cnt_ff == VER_LAST) begin
          if (fb_bad) det = sosc_pkg::CODE_FB_PWRUP;                                // [RL15]
          else if (FAULT_FLAGS_IN[sosc_pkg::FLG_MONITOR]) det = sosc_pkg::CODE_MONITOR; // [RL16]
          else if (sns1_s) det = sosc_pkg::CODE_PWR1;                               // [RL14]
          else if (sns2_s) det = sosc_pkg::CODE_PWR2;
          else nxt_state = sosc_pkg::ST_TEST;
        end
      end
      sosc_pkg::ST_TEST: begin
        // Short pulse on output 1 only; output 2 echoing it means a bridge
        nxt_cnt = cnt_ff + 11'h001;
        if (cnt_ff == TEST_LAST) begin
          if (sns2_s) det = sosc_pkg::CODE_SHORT12;                                 // [RL14]
          else begin
            test_pass = 1'b1;                                                       // [RL18]
            nxt_first = 1'b0;
            nxt_state = (opt == sosc_pkg::OPT_AUTO) ? sosc_pkg::ST_STOP : sosc_pkg::ST_WAIT; // [RL7] [RL9]
          end
        end
      end
      sosc_pkg::ST_WAIT: begin
        if (cnt_ff > SETTLE && sns1_s) det = sosc_pkg::CODE_PWR1;
        else if (cnt_ff > SETTLE && sns2_s) det = sosc_pkg::CODE_PWR2;
        else if (start_rise && !ZONE_BLOCKED_IN) begin                              // [RL7] [RL9]
          if (fb_bad) det = sosc_pkg::CODE_FB_PRE;                                  // [RL15]
          else begin
            nxt_state = sosc_pkg::ST_RUN;
            nxt_first = 1'b1;
          end
        end
      end
      sosc_pkg::ST_RUN: begin
        if (ZONE_BLOCKED_IN) nxt_state = sosc_pkg::ST_STOP;                         // [RL2]
        else if (cnt_ff > SETTLE && !sns1_s) det = sosc_pkg::CODE_GND1;             // [RL14]
        else if (cnt_ff > SETTLE && !sns2_s) det = sosc_pkg::CODE_GND2;
        else if (fb_en && fb_s && cnt_ff >= FB_TICKS) det = sosc_pkg::CODE_FB_POST; // [RL15]
      end
      sosc_pkg::ST_STOP: begin
        if (cnt_ff > SETTLE && sns1_s) det = sosc_pkg::CODE_PWR1;                   // [RL14]
        else if (cnt_ff > SETTLE && sns2_s) det = sosc_pkg::CODE_PWR2;
        else if (opt == sosc_pkg::OPT_RESTART || opt == 2'h3) nxt_state = sosc_pkg::ST_WAIT; // [RL9]
        else if (opt == sosc_pkg::OPT_START && !first_ff) nxt_state = sosc_pkg::ST_WAIT;    // [RL8]
        else if (!ZONE_BLOCKED_IN) begin                                            // [RL1]
          if (fb_bad) det = sosc_pkg::CODE_FB_PRE;                                  // [RL15]
          else nxt_state = sosc_pkg::ST_RUN;
        end
      end
      sosc_pkg::ST_FAULT: begin
        if (start_rise) nxt_state = sosc_pkg::ST_LAMP;                              // [RL4]
      end
      default: nxt_state = sosc_pkg::ST_FAULT;
    endcase
    if (state_ff != sosc_pkg::ST_FAULT && flag_code(FAULT_FLAGS_IN) != sosc_pkg::CODE_NONE) begin
      det = flag_code(FAULT_FLAGS_IN);                                              // [RL13] [RL16]
    end
    if (det != sosc_pkg::CODE_NONE) nxt_state = sosc_pkg::ST_FAULT;                 // [RL3]
    if (nxt_state != state_ff) nxt_cnt = '0;
  end

  // First fault latch; a new fault wins over the clear
  always_comb begin
    nxt_fault = fault_ff;
    if (test_pass) nxt_fault = sosc_pkg::CODE_NONE;                                 // [RL18]
    if (det != sosc_pkg::CODE_NONE && (fault_ff == sosc_pkg::CODE_NONE || test_pass)) begin
      nxt_fault = det;
    end
  end

  // Millisecond tick and fault flasher
  always_comb begin
    nxt_tick_cnt  = tick ? '0 : tick_cnt_ff + 15'h0001;
    nxt_flash_cnt = flash_cnt_ff;
    nxt_flash     = flash_ff;
    if (tick) begin
      nxt_flash_cnt = (flash_cnt_ff == FLASH_LAST) ? '0 : flash_cnt_ff + 11'h001;
      if (flash_cnt_ff == FLASH_LAST) nxt_flash = !flash_ff;
    end
  end

  // Displays: status codes never reach the beams
  always_comb begin
    nxt_pm   = sosc_pkg::CODE_NONE;
    nxt_beam = '0;
    case (nxt_state)
      sosc_pkg::ST_LAMP: begin
        nxt_pm   = sosc_pkg::STAT_LAMP;
        nxt_beam = '1;                                                              // [RL12]
      end
      sosc_pkg::ST_VER: begin
        nxt_pm   = sosc_pkg::VERSION_CODE;
        nxt_beam = {2'h0, sosc_pkg::VERSION_CODE};                                  // [RL12]
      end
      sosc_pkg::ST_FAULT: begin
        nxt_pm   = nxt_fault;
        nxt_beam = {2'h0, nxt_fault};                                               // [RL11] [RL17]
      end
      sosc_pkg::ST_WAIT: nxt_pm = sosc_pkg::STAT_WAIT;                              // [RL10]
      default: begin
        if (ctrl_ff[sosc_pkg::CTRL_MUTE]) nxt_pm = sosc_pkg::STAT_MUTE;             // [RL10]
        else if (ctrl_ff[sosc_pkg::CTRL_FLOAT] && ctrl_ff[sosc_pkg::CTRL_FIXED]) nxt_pm = sosc_pkg::STAT_BOTH;
        else if (ctrl_ff[sosc_pkg::CTRL_FIXED]) nxt_pm = sosc_pkg::STAT_FIXED;
        else if (ctrl_ff[sosc_pkg::CTRL_FLOAT]) nxt_pm = sosc_pkg::STAT_FLOAT;
      end
    endcase
  end

  // APB slave: zero wait, read data captured in the setup cycle
  always_comb begin
    mapped = (PADDR_IN == sosc_pkg::ADDR_CTRL) || (PADDR_IN == sosc_pkg::ADDR_STATUS) ||
             (PADDR_IN == sosc_pkg::ADDR_FAULT) || (PADDR_IN == sosc_pkg::ADDR_VERSION);
    nxt_ctrl   = ctrl_ff;
    nxt_prdata = prdata_ff;
    if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == sosc_pkg::ADDR_CTRL) begin
      nxt_ctrl = PWDATA_IN[sosc_pkg::CTRL_W-1:0];
    end
    if (PSEL_IN && !PENABLE_IN) begin
      case (PADDR_IN)
        sosc_pkg::ADDR_CTRL:    nxt_prdata = {26'h0, ctrl_ff};
        sosc_pkg::ADDR_STATUS:  nxt_prdata = {16'h0, pm_ff, 5'h0, state_ff};
        sosc_pkg::ADDR_FAULT:   nxt_prdata = {24'h0, fault_ff};                     // [RL18]
        sosc_pkg::ADDR_VERSION: nxt_prdata = {24'h0, sosc_pkg::VERSION_CODE};
        default:                nxt_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_ff      <= sosc_pkg::ST_LAMP;
      cnt_ff        <= '0;
      tick_cnt_ff   <= '0;
      flash_cnt_ff  <= '0;
      flash_ff      <= 1'b0;
      start_prev_ff <= 1'b0;
      first_ff      <= 1'b0;
      fault_ff      <= sosc_pkg::CODE_NONE;
      pm_ff         <= sosc_pkg::STAT_LAMP;
      beam_ff       <= '1;
      ctrl_ff       <= sosc_pkg::CTRL_RST;
      prdata_ff     <= '0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      tick_cnt_ff   <= nxt_tick_cnt;
      flash_cnt_ff  <= nxt_flash_cnt;
      flash_ff      <= nxt_flash;
      start_prev_ff <= start_s;
      first_ff      <= nxt_first;
      fault_ff      <= nxt_fault;
      pm_ff         <= nxt_pm;
      beam_ff       <= nxt_beam;
      ctrl_ff       <= nxt_ctrl;
      prdata_ff     <= nxt_prdata;
    end
  end

  assign PREADY_OUT      = 1'b1;
  assign PSLVERR_OUT     = PSEL_IN && PENABLE_IN && !mapped;
  assign PRDATA_OUT      = prdata_ff;
  assign SAFETY_OUT1_OUT = (state_ff == sosc_pkg::ST_RUN) || (state_ff == sosc_pkg::ST_TEST); // [RL5]
  assign SAFETY_OUT2_OUT = (state_ff == sosc_pkg::ST_RUN);                          // [RL5] [RL6]
  assign LED_RUN_OUT     = (state_ff == sosc_pkg::ST_RUN);                          // [RL5]
  assign LED_STOP_OUT    = (state_ff == sosc_pkg::ST_STOP) || (state_ff == sosc_pkg::ST_WAIT); // [RL6]
  assign LED_WAIT_OUT    = (state_ff == sosc_pkg::ST_WAIT) ||
                           (state_ff == sosc_pkg::ST_FAULT && flash_ff);             // [RL17]
  assign BEAM_IND_OUT    = beam_ff;
  assign PM_CODE_OUT     = pm_ff;

  run_lamps_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL5]
    state_ff == sosc_pkg::ST_RUN |-> SAFETY_OUT1_OUT && SAFETY_OUT2_OUT && LED_RUN_OUT && !LED_STOP_OUT && !LED_WAIT_OUT)
    else $error("run state outputs wrong");
  stop_lamps_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL6]
    state_ff == sosc_pkg::ST_STOP |-> !SAFETY_OUT1_OUT && !SAFETY_OUT2_OUT && !LED_RUN_OUT && LED_STOP_OUT)
    else $error("stop state outputs wrong");
  zone_trip_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL2]
    state_ff == sosc_pkg::ST_RUN && ZONE_BLOCKED_IN |=> !SAFETY_OUT1_OUT && !SAFETY_OUT2_OUT)
    else $error("blocked zone did not trip outputs");
  fault_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL3]
    state_ff == sosc_pkg::ST_FAULT && !start_rise |=> state_ff == sosc_pkg::ST_FAULT && !SAFETY_OUT1_OUT)
    else $error("fault hold left without start");
  fault_release_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL4]
    state_ff == sosc_pkg::ST_FAULT && start_rise |=> state_ff == sosc_pkg::ST_LAMP ##1 BEAM_IND_OUT == 10'h3FF)
    else $error("start did not launch self-test");
  beam_quiet_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL11]
    $past(state_ff) == sosc_pkg::ST_WAIT && state_ff == sosc_pkg::ST_WAIT |-> BEAM_IND_OUT == 10'h000
      && PM_CODE_OUT == sosc_pkg::STAT_WAIT)
    else $error("status code on beams or wrong wait code");
  fault_show_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL17]
    state_ff == sosc_pkg::ST_FAULT |-> BEAM_IND_OUT == {2'h0, fault_ff} && !LED_RUN_OUT)
    else $error("fault code not on beams");
  latch_stable_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL18]
    fault_ff != sosc_pkg::CODE_NONE && !test_pass |=> $stable(fault_ff))
    else $error("latched fault code changed");
  auto_run_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL1]
    state_ff == sosc_pkg::ST_STOP && opt == sosc_pkg::OPT_AUTO && !ZONE_BLOCKED_IN && !fb_bad
      && !sns1_s && !sns2_s && FAULT_FLAGS_IN == 8'h00 |=> state_ff == sosc_pkg::ST_RUN)
    else $error("automatic start did not run");
  wait_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [RL7]
    state_ff == sosc_pkg::ST_WAIT && !start_rise |=> state_ff != sosc_pkg::ST_RUN)
    else $error("run entered without start");
endmodule

// file: sosc_machine.sv
// Guarded machine model: contactor, output readback and start button
`timescale 1ns/1ps
module sosc_machine (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       safety1_in,
  input  wire logic       safety2_in,
  input  wire logic       start_req_in,
  input  wire logic [1:0] gnd_short_in,
  output logic            feedback_out,
  output logic            sense1_out,
  output logic            sense2_out,
  output logic            start_out
);
  logic [2:0] coil_ff;
  logic [2:0] nxt_coil;

  // Coil needs both outputs, so a short test pulse on one never pulls in
  always_comb begin
    nxt_coil = {coil_ff[1:0], safety1_in & safety2_in};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      coil_ff <= 3'h0;
    end else begin
      coil_ff <= nxt_coil;
    end
  end

  // Contacts closed while released; opens three cycles after pull-in
  assign feedback_out = ~coil_ff[2];
  // Readback follows the wire unless a short to ground is injected
  assign sense1_out   = safety1_in & ~gnd_short_in[0];
  assign sense2_out   = safety2_in & ~gnd_short_in[1];
  // Start button level; its rising edge is the start transition
  assign start_out    = start_req_in;
endmodule

// file: tb_sosc_ctrl.sv
// Self-checking bench for the safety output state controller
`timescale 1ns/1ps
module tb_sosc_ctrl;
  logic        clk, rst_n, psel, penable, pwrite, zone, start_req, err;
  logic        pready, pslverr, fb, s1, s2, start_pin, o1, o2, l_run, l_stop, l_wait;
  logic [1:0]  gnd;
  logic [7:0]  paddr, flags, pm;
  logic [9:0]  beam;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, checks_done, cycles;
  localparam int TB_TICK = 2;
  logic [7:0]  flg_tab [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00, 8'h00};
  logic [1:0]  gnd_tab [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [7:0]  code_tab [9] = '{sosc_pkg::CODE_MODE, sosc_pkg::CODE_SWCHG, sosc_pkg::CODE_MISMATCH,
    sosc_pkg::CODE_STORE, sosc_pkg::CODE_SCAN, sosc_pkg::CODE_LOGIC, sosc_pkg::CODE_XTALK,
    sosc_pkg::CODE_GND1, sosc_pkg::CODE_GND2};
  logic [7:0]  stat_tab [4] = '{sosc_pkg::STAT_FLOAT, sosc_pkg::STAT_FIXED, sosc_pkg::STAT_BOTH, sosc_pkg::STAT_MUTE};
  logic [5:0]  ctrl_tab [4] = '{6'h0C, 6'h14, 6'h1C, 6'h24};

  // Shortened tick keeps each self-test near 4000 cycles
  sosc_ctrl #(.TICK_CYC(TB_TICK)) sosc_ctrl_i (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .ZONE_BLOCKED_IN(zone), .FAULT_FLAGS_IN(flags), .START_IN(start_pin),
    .FEEDBACK_IN(fb), .SENSE1_IN(s1), .SENSE2_IN(s2), .SAFETY_OUT1_OUT(o1), .SAFETY_OUT2_OUT(o2),
    .LED_RUN_OUT(l_run), .LED_STOP_OUT(l_stop), .LED_WAIT_OUT(l_wait), .BEAM_IND_OUT(beam), .PM_CODE_OUT(pm));
  sosc_machine sosc_machine_i (.clk_in(clk), .rst_n_in(rst_n), .safety1_in(o1), .safety2_in(o2),
    .start_req_in(start_req), .gnd_short_in(gnd), .feedback_out(fb), .sense1_out(s1), .sense2_out(s2),
    .start_out(start_pin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic pulse();
    @(posedge clk) start_req <= 1'b1;
    repeat (4) @(posedge clk);
    start_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_run();
    while (l_run !== 1'b1) @(negedge clk);
  endtask

  task automatic fault_cycle(input int i, input logic hold);
    logic lw;
    int   n, t0, per;
    @(posedge clk);
    flags <= flg_tab[i]; gnd <= gnd_tab[i];
    while (pm !== code_tab[i]) @(negedge clk);
    @(posedge clk);
    flags <= 8'h00; gnd <= 2'h0;
    @(negedge clk);
    lw = l_wait;
    n = 0;
    t0 = 0;
    per = 0;
    // Cause gone, yet the hold must stay; time the flasher between two toggles
    for (int c = 0; c < 1020; c++) begin
      @(negedge clk);
      if (l_wait !== lw) begin
        n++;
        if (n == 2) per = c - t0;
        t0 = c;
        lw = l_wait;
      end
    end
    chk({o1, o2, l_run}, 3'h0);
    chk(per, sosc_pkg::FLASH_TIME_MS * TB_TICK);
    chk(beam, {2'h0, code_tab[i]});
    apb(1'b0, sosc_pkg::ADDR_FAULT, 32'h0000_0000);
    chk(rd, {24'h00_0000, code_tab[i]});
    pulse();
    @(negedge clk);
    chk(beam, 10'h3FF);
    while (beam !== {2'h0, sosc_pkg::VERSION_CODE}) @(negedge clk);
    if (hold) begin
      while (beam !== 10'h000) @(negedge clk);
      repeat (50) @(negedge clk);
      chk({l_run, pm}, {1'b0, sosc_pkg::STAT_WAIT});
      pulse();
    end
    wait_run();
    apb(1'b0, sosc_pkg::ADDR_FAULT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic stop_test();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Eleven self-tests plus flasher timing come to about 55000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    {psel, penable, pwrite, zone, start_req, err} = 6'h00;
    {gnd, paddr, flags, pwdata} = 50'h0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({beam, pm, o1, o2}, {10'h3FF, sosc_pkg::STAT_LAMP, 2'h0});
    apb(1'b0, sosc_pkg::ADDR_VERSION, 32'h0000_0000);
    chk(rd, {24'h00_0000, sosc_pkg::VERSION_CODE});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    wait_run();
    chk({o1, o2, l_run, l_stop, l_wait, beam}, {5'h1C, 10'h000});
    @(posedge clk) zone <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({o1, o2, l_run, l_stop}, 4'h1);
    // Contactor needs a few cycles to drop out before the zone clears
    repeat (10) @(posedge clk);
    zone <= 1'b0;
    wait_run();
    apb(1'b1, sosc_pkg::ADDR_CTRL, 32'h0000_0006);
    @(posedge clk) zone <= 1'b1;
    repeat (3) @(posedge clk);
    zone <= 1'b0;
    repeat (20) @(negedge clk);
    chk({o1, o2, l_run, l_wait, pm, beam}, {4'h1, sosc_pkg::STAT_WAIT, 10'h000});
    apb(1'b0, sosc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, {16'h0000, sosc_pkg::STAT_WAIT, 8'h03});
    pulse();
    @(negedge clk);
    chk(l_run, 1'b1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, sosc_pkg::ADDR_CTRL, {26'h0, ctrl_tab[k]});
      repeat (3) @(negedge clk);
      chk({pm, beam}, {stat_tab[k], 10'h000});
    end
    apb(1'b1, sosc_pkg::ADDR_CTRL, 32'h0000_0004);
    for (int i = 0; i < 9; i++) fault_cycle(i, 1'b0);
    apb(1'b1, sosc_pkg::ADDR_CTRL, 32'h0000_0005);
    fault_cycle(0, 1'b1);
    @(posedge clk) zone <= 1'b1;
    repeat (10) @(posedge clk);
    zone <= 1'b0;
    repeat (30) @(negedge clk);
    chk(l_run, 1'b1);
    stop_test();
  end
endmodule
